// File: design/cca_top.sv
// counter array: shared counter, timebase, flags and five capture/compare modules
// assumes a byte-wide register port on mclk and pins from outside the clock domain
module cca_top
    import cca_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic cpu_idle,
    input wire logic timer0_ovf,
    input wire logic external_count_input,
    input wire logic ext_osc,
    input wire logic [NUM_MOD-1:0] module_pin_i,
    output logic [NUM_MOD-1:0] module_pin_o,
    output logic [NUM_MOD-1:0] module_pin_oe,
    output logic watchdog_function_on,
    output logic irq_req
);
    // ************************************************
    // reset release
    // ************************************************
    logic rs1_r, rst_sync_b;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rs1_r <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_sync_b <= rs1_r;
        end
    end

    // ************************************************
    // pin synchronisers
    // ************************************************
    logic [NUM_MOD+1:0] pins_s;
    logic eci_s, osc_s;
    logic [NUM_MOD-1:0] mpin_s;

    cca_sync #(
        .W(NUM_MOD + 2)
    ) u_sync (
        .mclk(mclk),
        .rst_b(rst_sync_b),
        .d({ext_osc, external_count_input, module_pin_i}),
        .q(pins_s)
    );

    assign osc_s = pins_s[NUM_MOD+1];
    assign eci_s = pins_s[NUM_MOD];
    assign mpin_s = pins_s[NUM_MOD-1:0];

    // ************************************************
    // control registers
    // ************************************************
    logic idle_halt_r, wd_r, ecf_r, run_r, cf_r;
    logic [2:0] tb_r;
    logic [NUM_MOD-1:0] ccf_r;
    logic wr_mode_reg, wr_ctrl, wr_clo, wr_chi, rd_clo;

    assign wr_mode_reg = reg_wr && (reg_addr == ADDR_MODE);
    assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
    assign wr_clo = reg_wr && (reg_addr == ADDR_CNT_LO);
    assign wr_chi = reg_wr && (reg_addr == ADDR_CNT_HI);
    assign rd_clo = reg_rd && (reg_addr == ADDR_CNT_LO);

    // while the watchdog runs only its own enable bit may change
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            idle_halt_r <= MODE_RESET[MD_IDLE];
            wd_r <= MODE_RESET[MD_WD]; // [R20]
            tb_r <= MODE_RESET[3:1];
            ecf_r <= MODE_RESET[MD_ECF];
        end else if (wr_mode_reg) begin
            wd_r <= reg_wdata[MD_WD];
            if (!wd_r) begin
                idle_halt_r <= reg_wdata[MD_IDLE];
                tb_r <= reg_wdata[3:1];
                ecf_r <= reg_wdata[MD_ECF];
            end // [R21]
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            run_r <= 1'b0;
        end else if (wr_ctrl) begin
            run_r <= reg_wdata[CT_RUN];
        end
    end

    assign watchdog_function_on = wd_r;

    // ************************************************
    // timebase
    // ************************************************
    logic [3:0] pre_r;
    logic [2:0] osc_div_r;
    logic eci_d_r, osc_d_r, eci_fall, osc_tick, tick, run, adv;

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pre_r <= 4'h0;
        end else if (pre_r == PRE_DIV12 - 4'h1) begin
            pre_r <= 4'h0;
        end else begin
            pre_r <= pre_r + 4'h1;
        end
    end

    // edge detectors look at the second flop only
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            eci_d_r <= 1'b0;
            osc_d_r <= 1'b0;
            osc_div_r <= 3'h0;
        end else begin
            eci_d_r <= eci_s;
            osc_d_r <= osc_s;
            if (osc_s && !osc_d_r) begin
                osc_div_r <= osc_div_r + 3'h1;
            end
        end
    end

    assign eci_fall = eci_d_r && !eci_s; // [R26]
    assign osc_tick = osc_s && !osc_d_r && (osc_div_r == OSC_DIV_LAST); // [R6]

    always_comb begin
        unique case (tb_r)
            TB_DIV12: tick = (pre_r == PRE_DIV12 - 4'h1); // [R4]
            TB_DIV4: tick = (pre_r[1:0] == PRE_DIV4_LAST); // [R4]
            TB_T0: tick = timer0_ovf; // [R5]
            TB_ECI: tick = eci_fall; // [R5]
            TB_SYS: tick = 1'b1; // [R4]
            TB_OSC: tick = osc_tick; // [R6]
            default: tick = 1'b0; // [R27]
        endcase
    end

    assign run = run_r && !(cpu_idle && idle_halt_r); // [R10]
    assign adv = run && tick;

    // ************************************************
    // shared counter
    // ************************************************
    logic [15:0] cnt_r;
    logic [7:0] snap_r;
    logic adv_r, ovf8_r, ovf16_r;

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cnt_r <= 16'h0000;
        end else if (wr_clo) begin
            cnt_r[7:0] <= reg_wdata;
        end else if (wr_chi) begin
            cnt_r[15:8] <= reg_wdata;
        end else if (adv) begin
            cnt_r <= cnt_r + 16'h0001; // [R1]
        end
    end

    // compare events look at the counter one cycle after it moves
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            adv_r <= 1'b0;
            ovf8_r <= 1'b0;
            ovf16_r <= 1'b0;
        end else begin
            adv_r <= adv && !wr_clo && !wr_chi;
            ovf8_r <= adv && !wr_clo && !wr_chi && (cnt_r[7:0] == 8'hff);
            ovf16_r <= adv && !wr_clo && !wr_chi && (cnt_r == 16'hffff); // [R7]
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            snap_r <= 8'h00;
        end else if (rd_clo) begin
            snap_r <= cnt_r[15:8]; // [R2]
        end
    end

    // ************************************************
    // capture/compare modules
    // ************************************************
    logic [7:0] mm [NUM_MOD];
    logic [15:0] cmp [NUM_MOD];
    logic [NUM_MOD-1:0] evt, eccf;

    for (genvar i = 0; i < NUM_MOD; i++) begin : g_mod
        localparam logic [7:0] BASE = ADDR_MOD_BASE + 8'(i * 3);
        logic lock;
        assign lock = wd_r && (i == WD_MOD); // [R21]
        assign eccf[i] = mm[i][MM_ECCF]; // [R17]

        cca_module u_mod (
            .mclk(mclk),
            .rst_b(rst_sync_b),
            .cnt(cnt_r),
            .adv_r(adv_r),
            .ovf8_r(ovf8_r),
            .ovf16_r(ovf16_r),
            .pin_s(mpin_s[i]),
            .wr_mode(reg_wr && !lock && (reg_addr == BASE)),
            .wr_lo(reg_wr && !lock && (reg_addr == BASE + 8'h01)),
            .wr_hi(reg_wr && (reg_addr == BASE + 8'h02)),
            .wdata(reg_wdata),
            .mode_o(mm[i]),
            .cmp_o(cmp[i]),
            .pin_o(module_pin_o[i]),
            .pin_oe(module_pin_oe[i]),
            .evt_o(evt[i])
        ); // [R13]
    end

    // ************************************************
    // flags and interrupt request
    // ************************************************
    // a hardware set in the clearing cycle wins; nothing clears on service
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cf_r <= 1'b0;
            ccf_r <= '0;
        end else begin
            cf_r <= ovf16_r || (wr_ctrl ? reg_wdata[CT_CF] : cf_r); // [R9]
            ccf_r <= evt | (wr_ctrl ? reg_wdata[NUM_MOD-1:0] : ccf_r); // [R11]
        end
    end

    // global and array enables live in the processor's interrupt logic [R12]
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= (cf_r && ecf_r) || |(ccf_r & eccf); // [R8]
        end
    end

    // ************************************************
    // register read
    // ************************************************
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= 8'h00;
            if (reg_addr == ADDR_MODE) begin
                reg_rdata <= {idle_halt_r, wd_r, 2'b00, tb_r, ecf_r};
            end
            if (reg_addr == ADDR_CTRL) begin
                reg_rdata <= {cf_r, run_r, 1'b0, ccf_r};
            end
            if (reg_addr == ADDR_CNT_LO) begin
                reg_rdata <= cnt_r[7:0]; // [R3]
            end
            if (reg_addr == ADDR_CNT_HI) begin
                reg_rdata <= snap_r; // [R2]
            end
            for (int i = 0; i < NUM_MOD; i++) begin
                if (reg_addr == ADDR_MOD_BASE + 8'(i * 3)) begin
                    reg_rdata <= mm[i];
                end
                if (reg_addr == ADDR_MOD_BASE + 8'(i * 3 + 1)) begin
                    reg_rdata <= cmp[i][7:0];
                end
                if (reg_addr == ADDR_MOD_BASE + 8'(i * 3 + 2)) begin
                    reg_rdata <= cmp[i][15:8];
                end
            end
        end
    end

    // ************************************************
    // checks
    // ************************************************
    property p_wrap_flag;
        @(posedge mclk) disable iff (!rst_sync_b)
        (adv && !wr_clo && !wr_chi && cnt_r == 16'hffff) |=> cnt_r == 16'h0000 ##1 cf_r;
    endproperty
    a_wrap_flag: assert property (p_wrap_flag) else $error("wrap did not set flag"); // [R7]

    property p_flag_sticky;
        @(posedge mclk) disable iff (!rst_sync_b)
        (cf_r && !wr_ctrl) |=> cf_r;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("overflow flag self-cleared"); // [R9]

    property p_irq_gate;
        @(posedge mclk) disable iff (!rst_sync_b)
        (cf_r && !ecf_r && ((ccf_r & eccf) == '0)) |=> !irq_req;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("masked overflow raised request"); // [R8]

    property p_set_wins;
        @(posedge mclk) disable iff (!rst_sync_b)
        (|evt) |=> (ccf_r & $past(evt)) == $past(evt);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("module event flag lost"); // [R11]

    property p_snapshot;
        @(posedge mclk) disable iff (!rst_sync_b)
        (rd_clo && !reg_wr) |=> snap_r == $past(cnt_r[15:8]);
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("snapshot missed high byte"); // [R2]

    property p_read_quiet;
        @(posedge mclk) disable iff (!rst_sync_b)
        (reg_rd && !reg_wr && adv) |=> cnt_r == $past(cnt_r) + 16'h0001;
    endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("read disturbed counter"); // [R3]

    property p_div4;
        @(posedge mclk) disable iff (!rst_sync_b)
        (tb_r == TB_DIV4 && adv) |=> (!adv || tb_r != TB_DIV4) [*3];
    endproperty
    a_div4: assert property (p_div4) else $error("divide by four ran fast"); // [R4]

    property p_reserved;
        @(posedge mclk) disable iff (!rst_sync_b)
        (tb_r[2:1] == 2'b11 && !reg_wr) |=> cnt_r == $past(cnt_r);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved timebase counted"); // [R27]

    property p_idle_runs;
        @(posedge mclk) disable iff (!rst_sync_b)
        (cpu_idle && !idle_halt_r && run_r && tb_r == TB_SYS && !reg_wr)
            |=> cnt_r == $past(cnt_r) + 16'h0001;
    endproperty
    a_idle_runs: assert property (p_idle_runs) else $error("counter stalled in idle"); // [R10]

    property p_wd_lock;
        @(posedge mclk) disable iff (!rst_sync_b)
        (wd_r && wr_mode_reg) |=> tb_r == $past(tb_r) && ecf_r == $past(ecf_r);
    endproperty
    a_wd_lock: assert property (p_wd_lock) else $error("locked mode field changed"); // [R21]
endmodule

// File: include/cca_pkg.sv
// constants shared by the counter array top and its capture/compare modules
// assumes one system clock domain and a byte-wide register port
// Operation
// R1 - shared 16-bit counter seen as two bytes
// R2 - low byte read snapshots high byte
// R3 - counter reads never disturb counting
// R4 - codes 000/001/100 pick div12, div4, sysclk
// R5 - 010 timer0 overflow, 011 count-pin falling edges
// R6 - 101 oscillator div 8; 110/111 reserved
// R7 - counter wrap sets overflow flag
// R8 - overflow interrupt only while its enable set
// R9 - software clears overflow flag, never hardware
// R10 - idle mode keeps counting unless halt selected
// R11 - flags always set; enables gate shared request
// R12 - processor also needs global and array enables
// R13 - five independent 16-bit modules, own pins
// R14 - mode bits 5:4 select capture edges
// R15 - mode bits 3:1 select timer/toggle/frequency/pwm
// R16 - mode bit 7 picks 8 or 16-bit pwm
// R17 - mode bit 0 enables module interrupt
// R18 - bit 6 comparator off: no toggle, pwm low
// R19 - pwm with bit 3 flags each match
// R20 - module 4 watchdog enabled after reset
// R21 - watchdog enabled locks some control writes
// R22 - capture copies counter, sets event flag
// R23 - compare low write clears, high sets comparator
// R24 - pin levels held two clocks minimum
// R25 - 8-bit pwm: set on match, clear, reload
// R26 - count pin synchronised, falling edge pulses
// R27 - reserved timebase keeps counter stopped
package cca_pkg;
    localparam int NUM_MOD = 5;
    localparam int WD_MOD = 4;
    // ************************************************
    // register addresses (module n at base + 3n)
    // ************************************************
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h01;
    localparam logic [7:0] ADDR_CNT_LO = 8'h02;
    localparam logic [7:0] ADDR_CNT_HI = 8'h03;
    localparam logic [7:0] ADDR_MOD_BASE = 8'h08;
    localparam logic [7:0] MOD_STRIDE = 8'h03;
    // ************************************************
    // fields and reset values
    // ************************************************
    localparam int MD_IDLE = 7;
    localparam int MD_WD = 6;
    localparam int MD_ECF = 0;
    localparam int CT_CF = 7;
    localparam int CT_RUN = 6;
    localparam int MM_PWM16 = 7;
    localparam int MM_ECOM = 6;
    localparam int MM_CAPP = 5;
    localparam int MM_CAPN = 4;
    localparam int MM_MAT = 3;
    localparam int MM_TOG = 2;
    localparam int MM_PWM = 1;
    localparam int MM_ECCF = 0;
    localparam logic [7:0] MODE_RESET = 8'h40;
    localparam logic [2:0] TB_DIV12 = 3'h0;
    localparam logic [2:0] TB_DIV4 = 3'h1;
    localparam logic [2:0] TB_T0 = 3'h2;
    localparam logic [2:0] TB_ECI = 3'h3;
    localparam logic [2:0] TB_SYS = 3'h4;
    localparam logic [2:0] TB_OSC = 3'h5;
    localparam logic [3:0] PRE_DIV12 = 4'hc;
    localparam logic [1:0] PRE_DIV4_LAST = 2'h3;
    localparam logic [2:0] OSC_DIV_LAST = 3'h7;
endpackage

// File: design/cca_sync.sv
// two-flop synchroniser for a group of pin levels
// assumes each bit is an independent level from outside mclk's domain
module cca_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= '0;
            q <= '0;
        end else begin
            s1_r <= d;
            q <= s1_r;
        end
    end
endmodule

// File: design/cca_module.sv
// one capture/compare module of the counter array
// assumes counter events arrive as registered one-cycle pulses, pin already synchronised
module cca_module
    import cca_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [15:0] cnt,
    input wire logic adv_r,
    input wire logic ovf8_r,
    input wire logic ovf16_r,
    input wire logic pin_s,
    input wire logic wr_mode,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [7:0] wdata,
    output logic [7:0] mode_o,
    output logic [15:0] cmp_o,
    output logic pin_o,
    output logic pin_oe,
    output logic evt_o
);
    logic [7:0] mode_r, lo_r, hi_r;
    logic prev_r, cap, swt, hso, frq, pwm, ecom, m16, m8, pm, capt, evt;

    // ************************************************
    // mode decode and compare
    // ************************************************
    assign cap = (mode_r[3:1] == 3'h0) && (mode_r[5:4] != 2'h0); // [R14]
    assign swt = (mode_r[5:1] == 5'h04); // [R15]
    assign hso = (mode_r[5:1] == 5'h06);
    assign frq = (mode_r[5:1] == 5'h03);
    assign pwm = (mode_r[5:4] == 2'h0) && mode_r[MM_PWM] && !mode_r[MM_TOG];
    assign ecom = mode_r[MM_ECOM];
    assign m16 = adv_r && (cnt == {hi_r, lo_r});
    assign m8 = adv_r && (cnt[7:0] == lo_r);
    assign pm = mode_r[MM_PWM16] ? m16 : m8; // [R16]
    // pin held two clocks, so a one-cycle lag in prev_r never misses an edge [R24]
    assign capt = cap && ((mode_r[MM_CAPP] && pin_s && !prev_r) ||
                          (mode_r[MM_CAPN] && !pin_s && prev_r));
    assign evt = capt || ((swt || hso) && ecom && m16) || // [R22]
                 (frq && ecom && mode_r[MM_MAT] && m16) ||
                 (pwm && ecom && mode_r[MM_MAT] && pm); // [R19]

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prev_r <= 1'b0;
            evt_o <= 1'b0;
        end else begin
            prev_r <= pin_s;
            evt_o <= evt;
        end
    end

    // ************************************************
    // mode and compare registers
    // ************************************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= 8'h00;
            lo_r <= 8'h00;
            hi_r <= 8'h00;
        end else if (wr_mode) begin
            mode_r <= wdata;
        end else if (wr_lo) begin
            lo_r <= wdata;
            mode_r[MM_ECOM] <= 1'b0; // [R23]
        end else if (wr_hi) begin
            hi_r <= wdata;
            mode_r[MM_ECOM] <= 1'b1; // [R23]
        end else if (capt) begin
            {hi_r, lo_r} <= cnt; // [R22]
        end else if (frq && ecom && m8) begin
            lo_r <= lo_r + hi_r;
        end else if (pwm && !mode_r[MM_PWM16] && ovf8_r) begin
            lo_r <= hi_r; // [R25]
        end
    end

    // ************************************************
    // pin drive
    // ************************************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_o <= 1'b0;
        end else if (pwm) begin
            // set beats clear so a zero compare gives full duty
            if (!ecom) begin
                pin_o <= 1'b0; // [R18]
            end else if (pm) begin
                pin_o <= 1'b1; // [R25]
            end else if (mode_r[MM_PWM16] ? ovf16_r : ovf8_r) begin
                pin_o <= 1'b0; // [R25]
            end
        end else if ((hso && ecom && m16) || (frq && ecom && m8)) begin
            pin_o <= !pin_o; // [R18]
        end
    end

    assign pin_oe = hso || frq || pwm;
    assign mode_o = mode_r;
    assign cmp_o = {hi_r, lo_r};

    property p_pwm_off;
        @(posedge mclk) disable iff (!rst_b)
        (pwm && !ecom && !wr_mode && !wr_hi) |=> !pin_o ##1 (!pin_o || ecom || !pwm);
    endproperty
    a_pwm_off: assert property (p_pwm_off) else $error("pwm pin high with comparator off"); // [R18]

    property p_cmp_lo_write;
        @(posedge mclk) disable iff (!rst_b)
        (wr_lo && !wr_mode) |=> !mode_r[MM_ECOM] && (lo_r == $past(wdata));
    endproperty
    a_cmp_lo_write: assert property (p_cmp_lo_write) else $error("low write kept comparator"); // [R23]
endmodule

// File: testbench/cca_ext_model.sv
// stand-in for the pins and count inputs outside the counter array
// assumes the bench calls its tasks; every line here is asynchronous to mclk
module cca_ext_model (
    output logic count_in,
    output logic osc,
    output logic [4:0] lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    // count input rests high, as behind a pull-up
    initial begin
        count_in = 1'b1;
        osc = 1'b0;
        lvl = 5'h00;
    end
    // 5 clocks per level, slower than sysclk/4
    task automatic fall(input int n);
        repeat (n) begin
            #100 count_in = 1'b0;
            #100 count_in = 1'b1;
        end
    endtask
    // runs only on request, period unrelated to mclk
    task automatic osc_run(input int n);
        repeat (2 * n) #37 osc = ~osc;
    endtask
    // level held 10 clocks, above the two-clock minimum
    task automatic pin(input int i, input logic v);
        lvl[i] = v;
        #200;
    endtask
endmodule

// File: testbench/tb_cca_top.sv
// self-checking bench for the counter array top
// assumes cca_ext_model drives the pins, count input and oscillator
module tb_cca_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cca_pkg::*;
    logic mclk = 1'b0, rst_b = 1'b0, rw = 1'b0, rr = 1'b0, idle = 1'b0, t0 = 1'b0;
    logic [7:0] ra = 8'h00, wd = 8'h00, rdat, d, m;
    logic cin, osc, wdog, irq, p0;
    logic [4:0] lvl, pin_i, pin_o, pin_oe;
    logic [15:0] v1, v2, cval;
    int num_errors = 0, num_checks = 0, seed = 48, hi_cnt;
    always #10 mclk = ~mclk;
    // design drives the wire while enabled, otherwise the far side does
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & lvl);
    cca_top u_cca_top (.mclk(mclk), .rst_b(rst_b), .reg_addr(ra), .reg_wr(rw), .reg_rd(rr),
        .reg_wdata(wd), .reg_rdata(rdat), .cpu_idle(idle), .timer0_ovf(t0),
        .external_count_input(cin), .ext_osc(osc), .module_pin_i(pin_i),
        .module_pin_o(pin_o), .module_pin_oe(pin_oe), .watchdog_function_on(wdog),
        .irq_req(irq));
    cca_ext_model u_cca_ext_model (.count_in(cin), .osc(osc), .lvl(lvl));
    // ****
    // bus cycles and checks
    // ****
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge mclk);
        ra = a;
        wd = v;
        rw = 1'b1;
        @(negedge mclk);
        rw = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge mclk);
        ra = a;
        rr = 1'b1;
        @(negedge mclk);
        rr = 1'b0;
        v = rdat;
    endtask
    // low byte first so the high byte comes from the snapshot
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a + 8'h01, v[15:8]);
    endtask
    task automatic wait_irq(input logic v);
        int k;
        for (k = 0; k < 20 && irq !== v; k++) @(negedge mclk);
        if (k == 20) begin
            num_errors++;
            final_report();
        end
    endtask
    // 48 clocks pass between the two snapshots of the rate loop for the codes that wait 44 clocks
    function automatic logic [15:0] exp_ticks(input logic [2:0] c);
        case (c)
            TB_SYS: return 16'd48;
            TB_DIV4: return 16'd12;
            TB_DIV12: return 16'd4;
            TB_T0: return 16'd5;
            TB_ECI, TB_OSC: return 16'd3;
            default: return 16'd0;
        endcase
    endfunction
    // module 3: count high samples of the pin over n clocks
    task automatic pwm(input logic [7:0] md, input logic [15:0] c, input logic hw,
            input logic [15:0] ld, input int n, input int exp);
        wr(ADDR_CTRL, 8'h00);
        wr(8'h11, md);
        wr(8'h12, c[7:0]);
        if (hw) wr(8'h13, c[15:8]);
        wr(ADDR_CNT_LO, ld[7:0]);
        wr(ADDR_CNT_HI, ld[15:8]);
        wr(ADDR_CTRL, 8'h40);
        hi_cnt = 0;
        repeat (4) @(negedge mclk);
        repeat (n) begin
            @(negedge mclk);
            hi_cnt += (pin_o[3] === 1'b1) ? 1 : 0;
        end
        chk(16'(hi_cnt), 16'(exp));
        chk(16'(pin_oe[3]), 16'h0001);
        rd(ADDR_CTRL, d);
        chk(16'(d[3]), 16'(md[3] & hw));
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        rst_b = 1'b1;
        repeat (3) @(negedge mclk);
        chk(16'(wdog), 16'h0001);
        rd(ADDR_MODE, d);
        chk(16'(d), 16'(MODE_RESET));
        wr(8'h14, 8'h42);
        rd(8'h14, d);
        chk(16'(d), 16'h0000);
        wr(ADDR_MODE, 8'h8f);
        rd(ADDR_MODE, d);
        chk(16'(d), 16'h0000);
        chk(16'(wdog), 16'h0000);
        wr(ADDR_CNT_LO, 8'he0);
        wr(ADDR_CTRL, 8'h40);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_MODE, {4'h0, 3'(i), 1'b0});
            idle = 1'($random(seed)) | (i == 4);
            rd16(ADDR_CNT_LO, v1);
            case (3'(i))
                TB_T0: repeat (5) begin
                    @(negedge mclk) t0 = 1'b1;
                    @(negedge mclk) t0 = 1'b0;
                end
                TB_ECI: u_cca_ext_model.fall(3);
                TB_OSC: u_cca_ext_model.osc_run(24);
                default: repeat (44) @(negedge mclk);
            endcase
            if (i == 2 || i == 3 || i == 5) repeat (10) @(negedge mclk);
            rd16(ADDR_CNT_LO, v2);
            chk(v2 - v1, exp_ticks(3'(i)));
        end
        idle = 1'b0;
        wr(ADDR_MODE, {4'h0, TB_SYS, 1'b0});
        wr(ADDR_CNT_LO, 8'hf0);
        wr(ADDR_CNT_HI, 8'hff);
        repeat (30) @(negedge mclk);
        rd(ADDR_CTRL, d);
        chk(16'(d), 16'h00c0);
        chk(16'(irq), 16'h0000);
        wr(ADDR_MODE, {4'h0, TB_SYS, 1'b1});
        wait_irq(1'b1);
        wr(ADDR_CTRL, 8'h40);
        wait_irq(1'b0);
        wr(ADDR_MODE, {4'h0, TB_SYS, 1'b0});
        for (int i = 0; i < 3; i++) begin
            m = (i == 0) ? 8'h20 : (i == 1) ? 8'h10 : 8'h30;
            wr(ADDR_MOD_BASE + 8'(3 * i), m);
            for (int e = 1; e >= 0; e--) begin
                cval = 16'($random(seed));
                wr(ADDR_CTRL, 8'h00);
                wr(ADDR_CNT_LO, cval[7:0]);
                wr(ADDR_CNT_HI, cval[15:8]);
                u_cca_ext_model.pin(i, 1'(e));
                rd(ADDR_CTRL, d);
                chk(16'(d[i]), 16'(m[4 + e]));
                if (m[4 + e]) rd16(ADDR_MOD_BASE + 8'(3 * i + 1), v1);
                if (m[4 + e]) chk(v1, cval);
            end
        end
        wr(8'h0b, 8'h49);
        wr(8'h0c, 8'h00);
        rd(8'h0b, d);
        chk(16'(d), 16'h0009);
        wr(8'h0d, 8'h20);
        rd(8'h0b, d);
        chk(16'(d), 16'h0049);
        wr(ADDR_CNT_LO, 8'hf8);
        wr(ADDR_CNT_HI, 8'h1f);
        wr(ADDR_CTRL, 8'h40);
        wait_irq(1'b1);
        rd(ADDR_CTRL, d);
        chk(16'(d), 16'h0042);
        wr(8'h0b, 8'h00);
        wr(8'h0e, 8'h4c);
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_CTRL, 8'h00);
            wr(8'h0f, 8'h10);
            if (k == 0) wr(8'h10, 8'h30);
            wr(ADDR_CNT_LO, 8'h00);
            wr(ADDR_CNT_HI, 8'h30);
            p0 = pin_o[2];
            wr(ADDR_CTRL, 8'h40);
            repeat (30) @(negedge mclk);
            chk(16'(pin_o[2]), 16'(p0 ^ (k == 0)));
        end
        pwm(8'h4a, 16'h8010, 1'b1, 16'h0000, 512, 368);
        pwm(8'h42, 16'h8010, 1'b0, 16'h0000, 256, 0);
        pwm(8'hca, 16'hff00, 1'b1, 16'hfe00, 512, 256);
        // frequency output: toggle every 0x20 counts, high byte added to low each match
        pwm(8'h46, 16'h2040, 1'b1, 16'h0000, 512, 228);
        final_report();
    end
    initial begin
        #1000000;
        num_errors++;
        final_report();
    end
endmodule
